// ===== imd_params.svh
// Timing constants, field positions and reset values for the integer mul/div datapath
`ifndef IMD_PARAMS_SVH
`define IMD_PARAMS_SVH
`define IMD_NREGS        32
`define IMD_XLEN         64
`define IMD_LAT_MUL16    3
`define IMD_REP_MUL16    2
`define IMD_LAT_MUL32    4
`define IMD_REP_MUL32    3
`define IMD_STALL_MUL16  1
`define IMD_STALL_MUL32  2
`define IMD_LAT_DMUL     6
`define IMD_REP_DMUL     5
`define IMD_LAT_DIV      36
`define IMD_REP_DIV      36
`define IMD_LAT_DOUBLEWORD_DIVIDE_SIGNED     68
`define IMD_REP_DOUBLEWORD_DIVIDE_SIGNED     68
`define IMD_SMALL_MSB    15
`define IMD_RESULT_RESET 64'h0000_0000_0000_0000
`endif

// ===== imd_pkg.sv
// Types shared by the integer mul/div datapath
package imd_pkg;
	typedef enum logic [3:0] {
		IMD_ALU_ADD  = 4'h0,
		IMD_ALU_SUB  = 4'h1,
		IMD_ALU_AND  = 4'h2,
		IMD_ALU_OR   = 4'h3,
		IMD_ALU_XOR  = 4'h4,
		IMD_ALU_NOR  = 4'h5,
		IMD_ALU_SLL  = 4'h6,
		IMD_ALU_SRL  = 4'h7,
		IMD_ALU_SRA  = 4'h8,
		IMD_ALU_SLT  = 4'h9,
		IMD_ALU_SLTU = 4'ha
	} imd_alu_op_type;

	typedef enum logic [3:0] {
		IMD_MD_NONE  = 4'h0,
		IMD_MD_MULT  = 4'h1,
		IMD_MD_MULTU = 4'h2,
		IMD_MD_MADD  = 4'h3,
		IMD_MD_MADDU = 4'h4,
		IMD_MD_MULG  = 4'h5,
		IMD_MD_DMULS = 4'h6,
		IMD_MD_DMULU = 4'h7,
		IMD_MD_DIVS  = 4'h8,
		IMD_MD_WORD_DIVIDE_UNSIGNED  = 4'h9,
		IMD_MD_DDIVS = 4'ha,
		IMD_MD_DOUBLEWORD_DIVIDE_UNSIGNED = 4'hb
	} imd_md_op_type;

	typedef enum logic [1:0] {
		IMD_ST_IDLE  = 2'b00,
		IMD_ST_BUSY  = 2'b01,
		IMD_ST_DONE  = 2'b11
	} imd_state_type;
endpackage : imd_pkg

// ===== imd_datapath.sv
// Integer execution datapath: register file, ALU and pipelined multiply/divide unit
`include "imd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module imd_datapath #(
	parameter int XLEN  = `IMD_XLEN,
	parameter int NREGS = `IMD_NREGS
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic [4:0]            rd_addr_a,
	input  wire logic [4:0]            rd_addr_b,
	output logic      [XLEN-1:0]       rd_data_a,
	output logic      [XLEN-1:0]       rd_data_b,
	input  wire logic                  wr_en,
	input  wire logic [4:0]            wr_addr,
	input  wire logic [XLEN-1:0]       wr_data,
	input  wire logic                  alu_valid,
	input  wire imd_pkg::imd_alu_op_type alu_op,
	input  wire logic [XLEN-1:0]       alu_a,
	input  wire logic [XLEN-1:0]       alu_b,
	output logic      [XLEN-1:0]       alu_result,
	input  wire logic                  md_valid,
	input  wire imd_pkg::imd_md_op_type md_op,
	input  wire logic [4:0]            md_dest,
	input  wire logic                  hilo_read,
	output logic                       md_accept,
	output logic                       pipe_stall,
	output logic                       md_busy,
	output logic      [XLEN-1:0]       high_result_register,
	output logic      [XLEN-1:0]       low_result_register
);
	localparam int CW = 7;

	logic [XLEN-1:0] regs_r [NREGS];
	logic [XLEN-1:0] hi_r;
	logic [XLEN-1:0] lo_r;
	logic [XLEN-1:0] hi_nxt;
	logic [XLEN-1:0] lo_nxt;
	logic [CW-1:0]   lat_r;
	logic [CW-1:0]   rep_r;
	logic [CW-1:0]   lat_nxt;
	logic [CW-1:0]   rep_nxt;
	logic [1:0]      stall_r;
	logic [1:0]      stall_nxt;
	logic [3:0]      slot_v_r;
	logic [XLEN+4:0] slot_p_r [4];
	logic            md_fire;
	logic            small_ops;
	logic            gpr_wr;
	logic [4:0]      gpr_addr;
	logic [XLEN-1:0] gpr_val;
	imd_pkg::imd_state_type state_r;

	// Operand fits in a 16-bit field, sign-extended for signed ops and zero-extended otherwise
	function automatic logic fits16(input logic [XLEN-1:0] v, input logic sgn);
		logic [XLEN-1:0] ext;
		ext = sgn ? {{(XLEN-16){v[`IMD_SMALL_MSB]}}, v[15:0]} : {{(XLEN-16){1'b0}}, v[15:0]};
		return ext == v;
	endfunction

	// Signedness of a multiply/divide opcode
	function automatic logic is_signed(input imd_pkg::imd_md_op_type op);
		return op == imd_pkg::IMD_MD_MULT || op == imd_pkg::IMD_MD_MADD ||
			op == imd_pkg::IMD_MD_MULG || op == imd_pkg::IMD_MD_DMULS ||
			op == imd_pkg::IMD_MD_DIVS || op == imd_pkg::IMD_MD_DDIVS;
	endfunction

	// Register file reads with bypass from the write port and from a landing product
	always_comb begin
		rd_data_a = (rd_addr_a == 5'h00) ? '0 : regs_r[rd_addr_a];
		rd_data_b = (rd_addr_b == 5'h00) ? '0 : regs_r[rd_addr_b];
		if (gpr_wr && gpr_addr == rd_addr_a && rd_addr_a != 5'h00) begin
			rd_data_a = gpr_val;
		end
		if (gpr_wr && gpr_addr == rd_addr_b && rd_addr_b != 5'h00) begin
			rd_data_b = gpr_val;
		end
	end

	// Single write port: a landing multiply-to-register product wins; issue stalls the other
	always_comb begin
		gpr_wr   = wr_en;
		gpr_addr = wr_addr;
		gpr_val  = wr_data;
		if (slot_v_r[0]) begin
			gpr_wr   = 1'b1;
			gpr_addr = slot_p_r[0][XLEN+4:XLEN];
			gpr_val  = slot_p_r[0][XLEN-1:0];
		end
	end

	// Register storage; entry zero stays zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NREGS; i++) begin
				regs_r[i] <= `IMD_RESULT_RESET;
			end
		end else if (gpr_wr && gpr_addr != 5'h00) begin
			regs_r[gpr_addr] <= gpr_val;
		end
	end

	// Adder and logic/shift unit, one result per cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			alu_result <= '0;
		end else if (alu_valid) begin
			case (alu_op)
				imd_pkg::IMD_ALU_ADD:  alu_result <= alu_a + alu_b;
				imd_pkg::IMD_ALU_SUB:  alu_result <= alu_a - alu_b;
				imd_pkg::IMD_ALU_AND:  alu_result <= alu_a & alu_b;
				imd_pkg::IMD_ALU_OR:   alu_result <= alu_a | alu_b;
				imd_pkg::IMD_ALU_XOR:  alu_result <= alu_a ^ alu_b;
				imd_pkg::IMD_ALU_NOR:  alu_result <= ~(alu_a | alu_b);
				imd_pkg::IMD_ALU_SLL:  alu_result <= alu_a << alu_b[5:0];
				imd_pkg::IMD_ALU_SRL:  alu_result <= alu_a >> alu_b[5:0];
				imd_pkg::IMD_ALU_SRA:  alu_result <= $signed(alu_a) >>> alu_b[5:0];
				imd_pkg::IMD_ALU_SLT:  alu_result <= {63'd0, $signed(alu_a) < $signed(alu_b)};
				imd_pkg::IMD_ALU_SLTU: alu_result <= {63'd0, alu_a < alu_b};
				default:               alu_result <= '0;
			endcase
		end
	end

	// Issue accepted only when repeat window expired and the register write port (wr_en) is idle
	assign small_ops = fits16(alu_a, is_signed(md_op)) && fits16(alu_b, is_signed(md_op));
	assign md_accept = md_valid && md_op != imd_pkg::IMD_MD_NONE && rep_r == '0 && !wr_en;
	assign md_fire   = md_accept;
	assign md_busy   = state_r == imd_pkg::IMD_ST_BUSY;
	// Stall the pipe on mul-to-register slots and on early high/low reads
	assign pipe_stall = stall_r != 2'b00 || (hilo_read && lat_r != '0) ||
		(md_valid && !md_accept);

	// Timing table; the repeat counter holds blocked cycles, so it loads one less than repeat
	always_comb begin
		lat_nxt   = (lat_r != '0) ? lat_r - 7'h01 : lat_r;
		rep_nxt   = (rep_r != '0) ? rep_r - 7'h01 : rep_r;
		stall_nxt = (stall_r != 2'b00) ? stall_r - 2'b01 : stall_r;
		if (md_fire) begin
			stall_nxt = 2'b00;
			case (md_op)
				imd_pkg::IMD_MD_MULT, imd_pkg::IMD_MD_MULTU,
				imd_pkg::IMD_MD_MADD, imd_pkg::IMD_MD_MADDU: begin
					lat_nxt = small_ops ? CW'(`IMD_LAT_MUL16) : CW'(`IMD_LAT_MUL32);
					rep_nxt = small_ops ? CW'(`IMD_REP_MUL16 - 1) : CW'(`IMD_REP_MUL32 - 1);
				end
				imd_pkg::IMD_MD_MULG: begin
					lat_nxt   = small_ops ? CW'(`IMD_LAT_MUL16) : CW'(`IMD_LAT_MUL32);
					rep_nxt   = small_ops ? CW'(`IMD_REP_MUL16 - 1) : CW'(`IMD_REP_MUL32 - 1);
					stall_nxt = small_ops ? 2'(`IMD_STALL_MUL16) : 2'(`IMD_STALL_MUL32);
				end
				imd_pkg::IMD_MD_DMULS, imd_pkg::IMD_MD_DMULU: begin
					lat_nxt = CW'(`IMD_LAT_DMUL);
					rep_nxt = CW'(`IMD_REP_DMUL - 1);
				end
				imd_pkg::IMD_MD_DIVS, imd_pkg::IMD_MD_WORD_DIVIDE_UNSIGNED: begin
					lat_nxt = CW'(`IMD_LAT_DIV);
					rep_nxt = CW'(`IMD_REP_DIV - 1);
				end
				imd_pkg::IMD_MD_DDIVS, imd_pkg::IMD_MD_DOUBLEWORD_DIVIDE_UNSIGNED: begin
					lat_nxt = CW'(`IMD_LAT_DOUBLEWORD_DIVIDE_SIGNED);
					rep_nxt = CW'(`IMD_REP_DOUBLEWORD_DIVIDE_SIGNED - 1);
				end
				default: stall_nxt = 2'b00;
			endcase
		end
	end

	// Latency, repeat and stall counters
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lat_r   <= '0;
			rep_r   <= '0;
			stall_r <= 2'b00;
		end else begin
			lat_r   <= lat_nxt;
			rep_r   <= rep_nxt;
			stall_r <= stall_nxt;
		end
	end

	// Unit status for observation; result is computed and written at issue, early reads stalled until latency ends
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= imd_pkg::IMD_ST_IDLE;
		end else begin
			case (state_r)
				imd_pkg::IMD_ST_IDLE: if (md_fire) state_r <= imd_pkg::IMD_ST_BUSY;
				imd_pkg::IMD_ST_BUSY: if (lat_r == 7'h01 && !md_fire) begin
					state_r <= imd_pkg::IMD_ST_DONE;
				end
				imd_pkg::IMD_ST_DONE: state_r <= md_fire ? imd_pkg::IMD_ST_BUSY : imd_pkg::IMD_ST_IDLE;
				default:              state_r <= imd_pkg::IMD_ST_IDLE;
			endcase
		end
	end

	// Arithmetic for the issued operation; divide by zero yields all ones and the dividend
	always_comb begin
		logic [2*XLEN-1:0] prod;
		logic [2*XLEN-1:0] acc;
		logic [31:0]       a32;
		logic [31:0]       b32;
		prod = '0;
		a32  = alu_a[31:0];
		b32  = alu_b[31:0];
		hi_nxt = hi_r;
		lo_nxt = lo_r;
		acc  = {hi_r, lo_r};
		case (md_op)
			imd_pkg::IMD_MD_MULT, imd_pkg::IMD_MD_MADD, imd_pkg::IMD_MD_MULG:
				prod = (2*XLEN)'($signed({{32{a32[31]}}, a32}) * $signed({{32{b32[31]}}, b32}));
			imd_pkg::IMD_MD_MULTU, imd_pkg::IMD_MD_MADDU:
				prod = (2*XLEN)'({32'd0, a32} * {32'd0, b32});
			imd_pkg::IMD_MD_DMULS:
				prod = $signed({{XLEN{alu_a[XLEN-1]}}, alu_a}) * $signed({{XLEN{alu_b[XLEN-1]}}, alu_b});
			imd_pkg::IMD_MD_DMULU:
				prod = {{XLEN{1'b0}}, alu_a} * {{XLEN{1'b0}}, alu_b};
			default: prod = '0;
		endcase
		case (md_op)
			imd_pkg::IMD_MD_MULT, imd_pkg::IMD_MD_MULTU, imd_pkg::IMD_MD_MULG: begin
				hi_nxt = {{32{prod[63]}}, prod[63:32]};
				lo_nxt = {{32{prod[31]}}, prod[31:0]};
			end
			imd_pkg::IMD_MD_MADD, imd_pkg::IMD_MD_MADDU: begin
				acc    = (2*XLEN)'({hi_r[31:0], lo_r[31:0]} + prod[63:0]);
				hi_nxt = {{32{acc[63]}}, acc[63:32]};
				lo_nxt = {{32{acc[31]}}, acc[31:0]};
			end
			imd_pkg::IMD_MD_DMULS, imd_pkg::IMD_MD_DMULU: begin
				hi_nxt = prod[2*XLEN-1:XLEN];
				lo_nxt = prod[XLEN-1:0];
			end
			imd_pkg::IMD_MD_DIVS: begin
				lo_nxt = (b32 == '0) ? '1 : XLEN'($signed(a32) / $signed(b32));
				hi_nxt = (b32 == '0) ? XLEN'($signed(a32)) : XLEN'($signed(a32) % $signed(b32));
			end
			imd_pkg::IMD_MD_WORD_DIVIDE_UNSIGNED: begin
				lo_nxt = (b32 == '0) ? '1 : {32'd0, a32 / b32};
				hi_nxt = (b32 == '0) ? {32'd0, a32} : {32'd0, a32 % b32};
			end
			imd_pkg::IMD_MD_DDIVS: begin
				lo_nxt = (alu_b == '0) ? '1 : XLEN'($signed(alu_a) / $signed(alu_b));
				hi_nxt = (alu_b == '0) ? alu_a : XLEN'($signed(alu_a) % $signed(alu_b));
			end
			imd_pkg::IMD_MD_DOUBLEWORD_DIVIDE_UNSIGNED: begin
				lo_nxt = (alu_b == '0) ? '1 : alu_a / alu_b;
				hi_nxt = (alu_b == '0) ? alu_a : alu_a % alu_b;
			end
			default: lo_nxt = lo_r;
		endcase
	end

	// High/low result registers; mul-to-register leaves them untouched
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hi_r <= `IMD_RESULT_RESET;
			lo_r <= `IMD_RESULT_RESET;
		end else if (md_fire && md_op != imd_pkg::IMD_MD_MULG) begin
			hi_r <= hi_nxt;
			lo_r <= lo_nxt;
		end
	end

	// Products in flight to a register, one slot per cycle left, so overlapped ones all land
	always_ff @(posedge ref_clk) begin
		slot_v_r <= sys_rst ? 4'h0 : slot_v_r >> 1;
		for (int k = 0; k < 3; k++) begin
			slot_p_r[k] <= slot_p_r[k+1];
		end
		if (md_fire && md_op == imd_pkg::IMD_MD_MULG && !sys_rst) begin
			slot_v_r[lat_nxt[1:0] - 2'b01] <= 1'b1;
			slot_p_r[lat_nxt[1:0] - 2'b01] <= {md_dest, lo_nxt};
		end
	end

	assign high_result_register = hi_r;
	assign low_result_register  = lo_r;
endmodule // imd_datapath
`default_nettype wire

// ===== imd_props.sv
// Port-level timing and datapath checks for the integer mul/div datapath
`timescale 1ns/100ps
`default_nettype none
module imd_props (
	input wire logic			ref_clk,
	input wire logic			sys_rst,
	input wire logic [4:0]			rd_addr_a,
	input wire logic [63:0]			rd_data_a,
	input wire logic			wr_en,
	input wire logic [4:0]			wr_addr,
	input wire logic [63:0]			wr_data,
	input wire logic			alu_valid,
	input wire imd_pkg::imd_alu_op_type	alu_op,
	input wire logic [63:0]			alu_a,
	input wire logic [63:0]			alu_b,
	input wire logic [63:0]			alu_result,
	input wire logic			md_valid,
	input wire imd_pkg::imd_md_op_type	md_op,
	input wire logic			hilo_read,
	input wire logic			md_accept,
	input wire logic			pipe_stall,
	input wire logic			md_busy,
	input wire logic [63:0]			high_result_register,
	input wire logic [63:0]			low_result_register
);
	logic		sm;
	logic [7:0]	rep_n, lat_n, gap_r, rep_r, lat_r;

	// Expected repeat and latency of the op offered now; codes 1..5 are word multiplies
	always_comb begin
		if (md_op inside {4'h1, 4'h3, 4'h5})
			sm = (&alu_a[31:15] | ~|alu_a[31:15]) & (&alu_b[31:15] | ~|alu_b[31:15]);
		else
			sm = ~|alu_a[31:16] & ~|alu_b[31:16];
		rep_n = 8'h44;
		lat_n = 8'h44;
		if (md_op < 4'h6) begin
			rep_n = sm ? 8'h2 : 8'h3;
			lat_n = sm ? 8'h3 : 8'h4;
		end else if (md_op < 4'h8) begin
			rep_n = 8'h5;
			lat_n = 8'h6;
		end else if (md_op < 4'ha) begin
			rep_n = 8'h24;
			lat_n = 8'h24;
		end
	end

	// Cycles since the last accepted op; saturates so a long idle never wraps
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gap_r <= 8'h0;
			rep_r <= 8'h0;
			lat_r <= 8'h0;
		end else if (md_accept) begin
			gap_r <= 8'h1;
			rep_r <= rep_n;
			lat_r <= lat_n;
		end else if (gap_r != 8'hff)
			gap_r <= gap_r + 8'h1;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_repeat_gap: assert property (md_accept |-> gap_r >= rep_r)
		else $error("op taken before repeat interval");
	a_repeat_free: assert property (md_valid && md_op != imd_pkg::IMD_MD_NONE && !wr_en
		&& gap_r >= rep_r |-> md_accept) else $error("op held past repeat interval");
	a_latency_len: assert property ($fell(md_busy) |-> gap_r == lat_r + 8'h1)
		else $error("busy length differs from latency");
	a_mulg_stall: assert property (md_accept && md_op == imd_pkg::IMD_MD_MULG
		|=> pipe_stall ##1 (pipe_stall || $past(sm, 2))) else $error("short stall");
	a_no_stall: assert property (md_accept && md_op != imd_pkg::IMD_MD_MULG
		##1 !md_valid && !hilo_read |-> !pipe_stall) else $error("stray stall");
	a_alu_add: assert property (alu_valid && alu_op == imd_pkg::IMD_ALU_ADD
		|=> alu_result == $past(alu_a) + $past(alu_b)) else $error("bad sum");
	a_rf_bypass: assert property (wr_en && wr_addr == rd_addr_a && wr_addr != 5'h0
		&& !md_busy |-> rd_data_a == wr_data) else $error("no bypass");
	a_hilo_lock: assert property (hilo_read && md_busy |-> pipe_stall)
		else $error("early result read not held");
	a_refuse_stall: assert property (md_valid && md_op != 4'h0 && !md_accept |-> pipe_stall)
		else $error("refused op without stall");
	a_hilo_stand: assert property (!md_accept || md_op == imd_pkg::IMD_MD_MULG
		|=> $stable(high_result_register) && $stable(low_result_register))
		else $error("result registers moved");
endmodule // imd_props
bind imd_datapath imd_props chk_u (.*);
`default_nettype wire

// ===== imd_issue_model.sv
// Issue-stage model offering mul/div ops and holding each until it is taken
`timescale 1ns/100ps
`default_nettype none
module imd_issue_model (
	input wire logic			ref_clk,
	input wire logic			sys_rst,
	input wire logic			req,
	input wire imd_pkg::imd_md_op_type	req_op,
	input wire logic			md_accept,
	output logic				md_valid,
	output imd_pkg::imd_md_op_type		md_op
);
	// A refused op stays offered unchanged, as a stalled pipeline would hold it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			md_valid <= 1'b0;
			md_op <= imd_pkg::IMD_MD_NONE;
		end else if (!md_valid || md_accept) begin
			md_valid <= req;
			md_op <= req_op;
		end
	end
endmodule // imd_issue_model
`default_nettype wire

// ===== test_imd_datapath.sv
// Self-checking testbench for the integer mul/div datapath
`timescale 1ns/100ps
`default_nettype none
module test_imd_datapath;
	logic		ref_clk, md_valid, md_accept, pipe_stall, md_busy;
	logic		sys_rst = 1'b1, wr_en = 1'b0, alu_valid = 1'b0, hilo_read = 1'b0, req = 1'b0;
	logic [4:0]	rd_addr_a = 5'h0, rd_addr_b = 5'h0, wr_addr = 5'h0, md_dest = 5'h0;
	logic [63:0]	wr_data = 64'h0, alu_a = 64'h0, alu_b = 64'h0;
	logic [63:0]	rd_data_a, rd_data_b, alu_result, high_result_register, low_result_register;
	imd_pkg::imd_alu_op_type	alu_op = imd_pkg::IMD_ALU_ADD;
	imd_pkg::imd_md_op_type		md_op, req_op = imd_pkg::IMD_MD_NONE;
	int		failures = 0;
	int		n_checks = 0;

	imd_datapath dut_u (.*);
	imd_issue_model model_u (.*);

	// Free-running core clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bounded wait for the op on offer to be taken; n counts cycles
	task automatic wait_acc(output int n);
		for (n = 1; n <= 200; n++) begin
			@(negedge ref_clk);
			if (md_accept === 1'b1)
				return;
		end
		failures++;
		final_report();
	endtask

	// Same op issued twice back to back; repeat, latency, stall and results judged
	task automatic t_md(input imd_pkg::imd_md_op_type op, input logic [63:0] a, b, hi, lo,
		input int rep, lat, stl, input logic [4:0] d);
		int n, m, s;
		@(posedge ref_clk);
		alu_a <= a;
		alu_b <= b;
		md_dest <= d;
		req_op <= op;
		req <= 1'b1;
		wait_acc(n);
		@(posedge ref_clk);
		req <= 1'b0;
		wait_acc(n);
		chk(64'(n), 64'(rep));
		@(posedge ref_clk);
		s = 0;
		for (m = 0; m < 100; m++) begin
			@(negedge ref_clk);
			if (md_busy !== 1'b1)
				break;
			s += int'(pipe_stall === 1'b1);
		end
		chk(64'(m), 64'(lat));
		if (m == 100)
			final_report();
		chk(64'(s), 64'(stl));
		chk(high_result_register, hi);
		chk(low_result_register, lo);
	endtask

	// Each entry written and bypassed at once, then read back on the other port
	task automatic t_rf();
		for (int i = 0; i < 64; i++) begin
			@(posedge ref_clk);
			wr_en <= i < 32;
			wr_addr <= 5'(i);
			wr_data <= 64'h0101_0101_0101_0101 * 64'(i % 32 + 1);
			rd_addr_a <= 5'(i);
			rd_addr_b <= 5'(i);
			@(negedge ref_clk);
			chk(i < 32 ? rd_data_a : rd_data_b, i % 32 == 0 ? 64'h0 : wr_data);
		end
	endtask

	task automatic alu(input imd_pkg::imd_alu_op_type op, input logic [63:0] a, b, exp);
		@(posedge ref_clk);
		alu_valid <= 1'b1;
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk(alu_result, exp);
	endtask

	// Refusal while the write port is in use, then an early result read held back
	task automatic t_lock();
		int n;
		@(posedge ref_clk);
		alu_a <= 64'h9;
		alu_b <= 64'h3;
		req_op <= imd_pkg::IMD_MD_WORD_DIVIDE_UNSIGNED;
		req <= 1'b1;
		wr_en <= 1'b1;
		wr_addr <= 5'h3;
		wr_data <= 64'h77;
		rd_addr_a <= 5'h3;
		@(posedge ref_clk);
		req <= 1'b0;
		@(negedge ref_clk);
		chk({62'h0, md_accept, pipe_stall}, 64'h1);
		@(posedge ref_clk);
		wr_en <= 1'b0;
		wait_acc(n);
		@(posedge ref_clk);
		hilo_read <= 1'b1;
		@(negedge ref_clk);
		chk({62'h0, pipe_stall, md_busy}, 64'h3);
		repeat (40) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({62'h0, pipe_stall, md_busy}, 64'h0);
		chk(high_result_register, 64'h0);
		chk(low_result_register, 64'h3);
		chk(rd_data_a, 64'h77);
	endtask

	// Main sequence; register file and ALU ops first, then every mul/div op code
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_rf();
		alu(imd_pkg::IMD_ALU_ADD, 64'h5, 64'h3, 64'h8);
		alu(imd_pkg::IMD_ALU_SUB, 64'h3, 64'h5, -64'h2);
		alu(imd_pkg::IMD_ALU_AND, 64'hf0, 64'h3c, 64'h30);
		alu(imd_pkg::IMD_ALU_OR, 64'hf0, 64'hf, 64'hff);
		alu(imd_pkg::IMD_ALU_XOR, 64'hff, 64'hf, 64'hf0);
		alu(imd_pkg::IMD_ALU_NOR, 64'h0, 64'h0, -64'h1);
		alu(imd_pkg::IMD_ALU_SLL, 64'hf0, 64'h4, 64'hf00);
		alu(imd_pkg::IMD_ALU_SRL, 64'hf0, 64'h4, 64'hf);
		alu(imd_pkg::IMD_ALU_SRA, -64'h10, 64'h4, -64'h1);
		alu(imd_pkg::IMD_ALU_SLT, -64'h1, 64'h1, 64'h1);
		alu(imd_pkg::IMD_ALU_SLTU, -64'h1, 64'h1, 64'h0);
		t_md(imd_pkg::IMD_MD_MULT, 64'h3, -64'h2, -64'h1, -64'h6, 2, 3, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_MULTU, 64'h1_0000, 64'h1_0000, 64'h1, 64'h0, 3, 4, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_MADD, 64'h2, 64'h3, 64'h1, 64'hc, 2, 3, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_MADDU, 64'h2_0000, 64'h8000, 64'h3, 64'hc, 3, 4, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_DMULS, -64'h1, 64'h2, -64'h1, -64'h2, 5, 6, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_DMULU, 64'h8000_0000_0000_0000, 64'h4, 64'h2, 64'h0, 5, 6, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_DIVS, -64'h7, 64'h2, -64'h1, -64'h3, 36, 36, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_WORD_DIVIDE_UNSIGNED, 64'h64, 64'h7, 64'h2, 64'he, 36, 36, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_DDIVS, -64'h64, 64'h7, -64'h2, -64'he, 68, 68, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_DOUBLEWORD_DIVIDE_UNSIGNED, -64'h1, 64'h10, 64'hf, 64'h0fff_ffff_ffff_ffff, 68, 68, 0, 5'h0);
		t_md(imd_pkg::IMD_MD_MULG, 64'h5, -64'h3, 64'hf, 64'h0fff_ffff_ffff_ffff, 2, 3, 1, 5'h5);
		t_md(imd_pkg::IMD_MD_MULG, 64'h1_0000, 64'h3, 64'hf, 64'h0fff_ffff_ffff_ffff, 3, 4, 2, 5'h6);
		@(posedge ref_clk);
		rd_addr_a <= 5'h5;
		rd_addr_b <= 5'h6;
		@(negedge ref_clk);
		chk(rd_data_a, -64'hf);
		chk(rd_data_b, 64'h3_0000);
		t_lock();
		final_report();
	end
endmodule // test_imd_datapath
`default_nettype wire
